// ==== rtl/ism_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module ism_top (
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Middle byte event pulses
	input wire logic ref_input_nine,
	input wire logic ref_input_ten,
	input wire logic ref_input_eleven,
	input wire logic ref_input_twelve,
	input wire logic ref_input_thirteen,
	input wire logic main_ref_lost,
	// Upper byte event pulses
	input wire logic ext_frame_pulse_alarm,
	input wire logic aux_path_state_change,
	input wire logic phase_monitor_alarm,
	input wire logic aux_path_sources_lost,
	input wire logic bipolar_in2_code_error,
	input wire logic bipolar_in2_signal_loss,
	// Interrupt request, level
	output logic irq
);

	// ----------------------------------------
	// Mask registers and bus access
	// ----------------------------------------
	logic [7:0] mask_mid_ff;
	logic [7:0] mask_high_ff;
	logic [31:0] prdata_ff;
	logic [7:0] nxt_mask_mid;
	logic [7:0] nxt_mask_high;
	logic [31:0] nxt_prdata;
	logic [7:0] clr_mid;
	logic [7:0] clr_high;
	logic [7:0] ev_mid;
	logic [7:0] ev_high;
	logic [7:0] pend_mid;
	logic [7:0] pend_high;
	logic [7:0] act_mid;
	logic [7:0] act_high;
	logic wr_en;
	logic rd_en;
	logic hit;

	// Single-cycle access phase; setup cycle already gave decode time
	assign wr_en = psel && penable && pwrite && pstrb[0];
	assign rd_en = psel && !penable && !pwrite;
	assign pready = 1'b1;

	// Decode; unmapped addresses answer with an error
	always_comb
	begin
		hit = 1'b0;
		if (paddr == ism_pkg::ADDR_MASK_MID)
			hit = 1'b1;
		else if (paddr == ism_pkg::ADDR_MASK_HIGH)
			hit = 1'b1;
		else if (paddr == ism_pkg::ADDR_PEND_MID)
			hit = 1'b1;
		else if (paddr == ism_pkg::ADDR_PEND_HIGH)
			hit = 1'b1;
	end
	assign pslverr = psel && penable && !hit;

	// Mask writes; lane 0 carries the byte, upper lanes ignored
	always_comb
	begin
		nxt_mask_mid = mask_mid_ff;
		nxt_mask_high = mask_high_ff;
		clr_mid = 8'h00;
		clr_high = 8'h00;
		if (wr_en)
		begin
			if (paddr == ism_pkg::ADDR_MASK_MID)
				nxt_mask_mid = pwdata[ism_pkg::BYTE_W-1:0];
			else if (paddr == ism_pkg::ADDR_MASK_HIGH)
				nxt_mask_high = pwdata[ism_pkg::BYTE_W-1:0];
			else if (paddr == ism_pkg::ADDR_PEND_MID)
				clr_mid = pwdata[ism_pkg::BYTE_W-1:0];
			else if (paddr == ism_pkg::ADDR_PEND_HIGH)
				clr_high = pwdata[ism_pkg::BYTE_W-1:0];
		end
	end

	// Read data registered in the setup cycle, stable in access
	always_comb
	begin
		nxt_prdata = prdata_ff;
		if (rd_en)
		begin
			nxt_prdata = ism_pkg::RDATA_ZERO;
			if (paddr == ism_pkg::ADDR_MASK_MID)
				nxt_prdata[7:0] = mask_mid_ff;
			else if (paddr == ism_pkg::ADDR_MASK_HIGH)
				nxt_prdata[7:0] = mask_high_ff;
			else if (paddr == ism_pkg::ADDR_PEND_MID)
				nxt_prdata[7:0] = pend_mid;
			else if (paddr == ism_pkg::ADDR_PEND_HIGH)
				nxt_prdata[7:0] = pend_high;
		end
	end

	// Masks start cleared so every source is disabled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_mid_ff <= ism_pkg::MASK_RST;
			mask_high_ff <= ism_pkg::MASK_RST;
			prdata_ff <= ism_pkg::RDATA_ZERO;
		end
		else
		begin
			mask_mid_ff <= nxt_mask_mid;
			mask_high_ff <= nxt_mask_high;
			prdata_ff <= nxt_prdata;
		end
	end
	assign prdata = prdata_ff;

	// ----------------------------------------
	// Event mapping
	// ----------------------------------------
	// Unused bits tie low: their sources live outside this block
	always_comb
	begin
		ev_mid = 8'h00;
		ev_high = 8'h00;
		ev_mid[ism_pkg::BIT_REF9] = ref_input_nine;
		ev_mid[ism_pkg::BIT_REF10] = ref_input_ten;
		ev_mid[ism_pkg::BIT_REF11] = ref_input_eleven;
		ev_mid[ism_pkg::BIT_REF12] = ref_input_twelve;
		ev_mid[ism_pkg::BIT_REF13] = ref_input_thirteen;
		ev_mid[ism_pkg::BIT_MAIN_REF_FAIL] = main_ref_lost;
		ev_high[ism_pkg::BIT_EXT_FRAME] = ext_frame_pulse_alarm;
		ev_high[ism_pkg::BIT_AUX_CHANGE] = aux_path_state_change;
		ev_high[ism_pkg::BIT_PHASE_MON] = phase_monitor_alarm;
		ev_high[ism_pkg::BIT_AUX_LOST] = aux_path_sources_lost;
		ev_high[ism_pkg::BIT_BIP2_CODE] = bipolar_in2_code_error;
		ev_high[ism_pkg::BIT_BIP2_LOSS] = bipolar_in2_signal_loss;
	end

	// ----------------------------------------
	// Pending flags and gating
	// ----------------------------------------
	ism_gate_byte u_mid (
		.pclk(pclk),
		.presetn(presetn),
		.event_in(ev_mid),
		.mask(mask_mid_ff),
		.clr(clr_mid),
		.pend(pend_mid),
		.active(act_mid)
	);

	ism_gate_byte u_high (
		.pclk(pclk),
		.presetn(presetn),
		.event_in(ev_high),
		.mask(mask_high_ff),
		.clr(clr_high),
		.pend(pend_high),
		.active(act_high)
	);

	// Combinational so a mask change shows the cycle after the write
	assign irq = |{act_mid, act_high};

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_ref13;
		@(posedge pclk) disable iff (!presetn)
		(ref_input_thirteen && !mask_mid_ff[ism_pkg::BIT_REF13])
			|=> (pend_mid[ism_pkg::BIT_REF13] && !act_mid[ism_pkg::BIT_REF13]);
	endproperty
	a_ref13: assert property (p_ref13) else $error("ref13 not blocked");

	property p_ref12;
		@(posedge pclk) disable iff (!presetn)
		(ref_input_twelve && mask_mid_ff[ism_pkg::BIT_REF12] && !wr_en)
			|=> irq;
	endproperty
	a_ref12: assert property (p_ref12) else $error("ref12 irq missing");

	property p_ref11;
		@(posedge pclk) disable iff (!presetn)
		(act_mid[ism_pkg::BIT_REF11]) |-> mask_mid_ff[ism_pkg::BIT_REF11];
	endproperty
	a_ref11: assert property (p_ref11) else $error("ref11 gate wrong");

	property p_ref10;
		@(posedge pclk) disable iff (!presetn)
		(ref_input_ten && mask_mid_ff[ism_pkg::BIT_REF10] && !wr_en)
			|=> act_mid[ism_pkg::BIT_REF10];
	endproperty
	a_ref10: assert property (p_ref10) else $error("ref10 lost");

	property p_ref9;
		@(posedge pclk) disable iff (!presetn)
		(ref_input_nine && !clr_mid[ism_pkg::BIT_REF9])
			|=> pend_mid[ism_pkg::BIT_REF9] [*1] ##0
			(act_mid[ism_pkg::BIT_REF9] == mask_mid_ff[ism_pkg::BIT_REF9]);
	endproperty
	a_ref9: assert property (p_ref9) else $error("ref9 gate wrong");

	property p_ext;
		@(posedge pclk) disable iff (!presetn)
		(ext_frame_pulse_alarm && mask_high_ff[ism_pkg::BIT_EXT_FRAME]
			&& !wr_en) |=> irq;
	endproperty
	a_ext: assert property (p_ext) else $error("ext alarm irq missing");

	property p_aux;
		@(posedge pclk) disable iff (!presetn)
		(aux_path_state_change && !mask_high_ff[ism_pkg::BIT_AUX_CHANGE]
			&& !wr_en) |=> !act_high[ism_pkg::BIT_AUX_CHANGE];
	endproperty
	a_aux: assert property (p_aux) else $error("aux change not blocked");

	property p_lost;
		@(posedge pclk) disable iff (!presetn)
		(aux_path_sources_lost && mask_high_ff[ism_pkg::BIT_AUX_LOST]
			&& !wr_en) |=> act_high[ism_pkg::BIT_AUX_LOST];
	endproperty
	a_lost: assert property (p_lost) else $error("aux lost missing");

	property p_code;
		@(posedge pclk) disable iff (!presetn)
		(bipolar_in2_code_error && mask_high_ff[ism_pkg::BIT_BIP2_CODE]
			&& !wr_en) |=> act_high[ism_pkg::BIT_BIP2_CODE];
	endproperty
	a_code: assert property (p_code) else $error("code error missing");

	sequence s_mask_write;
		wr_en && paddr == ism_pkg::ADDR_MASK_MID;
	endsequence
	property p_wr;
		logic [7:0] d;
		@(posedge pclk) disable iff (!presetn)
		(s_mask_write, d = pwdata[7:0]) |=> (mask_mid_ff == d);
	endproperty
	a_wr: assert property (p_wr) else $error("mask write lost");

	property p_main;
		@(posedge pclk) disable iff (!presetn)
		(main_ref_lost && mask_mid_ff[ism_pkg::BIT_MAIN_REF_FAIL] && !wr_en)
			|=> act_mid[ism_pkg::BIT_MAIN_REF_FAIL];
	endproperty
	a_main: assert property (p_main) else $error("main ref missing");

	property p_phase;
		@(posedge pclk) disable iff (!presetn)
		act_high[ism_pkg::BIT_PHASE_MON] |-> mask_high_ff[ism_pkg::BIT_PHASE_MON];
	endproperty
	a_phase: assert property (p_phase) else $error("phase gate wrong");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		irq == |((pend_mid & mask_mid_ff) | (pend_high & mask_high_ff));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

endmodule

`default_nettype wire

// ==== include/ism_pkg.sv ====
package ism_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	// Printed offsets are not all multiples of four: they are indices
	localparam logic [7:0] IDX_MASK_MID = 8'h44;
	localparam logic [7:0] IDX_MASK_HIGH = 8'h45;
	localparam logic [7:0] IDX_PEND_MID = 8'h48;
	localparam logic [7:0] IDX_PEND_HIGH = 8'h49;
	localparam logic [11:0] ADDR_MASK_MID = {2'b00, IDX_MASK_MID, 2'b00};
	localparam logic [11:0] ADDR_MASK_HIGH = {2'b00, IDX_MASK_HIGH, 2'b00};
	localparam logic [11:0] ADDR_PEND_MID = {2'b00, IDX_PEND_MID, 2'b00};
	localparam logic [11:0] ADDR_PEND_HIGH = {2'b00, IDX_PEND_HIGH, 2'b00};

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int BYTE_W = 8;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] PEND_RST = 8'h00;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
	// Middle register
	localparam int BIT_REF9 = 0;
	localparam int BIT_REF10 = 1;
	localparam int BIT_REF11 = 2;
	localparam int BIT_REF12 = 3;
	localparam int BIT_REF13 = 4;
	localparam int BIT_MAIN_REF_FAIL = 6;
	// Upper register
	localparam int BIT_BIP2_LOSS = 2;
	localparam int BIT_BIP2_CODE = 3;
	localparam int BIT_AUX_LOST = 4;
	localparam int BIT_PHASE_MON = 5;
	localparam int BIT_AUX_CHANGE = 6;
	localparam int BIT_EXT_FRAME = 7;

endpackage

// ==== rtl/ism_gate_byte.sv ====
`timescale 1ns/1ps
`default_nettype none

// One byte of sticky pending flags, gated by an enable mask
module ism_gate_byte (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Events and mask
	input wire logic [7:0] event_in,
	input wire logic [7:0] mask,
	// Software clear, write one to clear
	input wire logic [7:0] clr,
	// Results
	output logic [7:0] pend,
	output logic [7:0] active
);

	logic [7:0] pend_ff;
	logic [7:0] nxt_pend;

	// Set wins over clear so an event in the clear cycle survives
	always_comb
	begin
		nxt_pend = (pend_ff & ~clr) | event_in;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_ff <= ism_pkg::PEND_RST;
		else
			pend_ff <= nxt_pend;
	end

	assign pend = pend_ff;
	assign active = pend_ff & mask;

endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0] pstrb;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [11:0] ev;
	logic irq;
	int n_fail;
	int n_tests;
	// Bit position of each source, mid sources first, then upper
	int bit_of [12] = '{0, 1, 2, 3, 4, 6, 7, 6, 5, 4, 3, 2};

	// ----------------------------------------
	// Design and clock
	// ----------------------------------------
	ism_top ism_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ref_input_nine(ev[0]), .ref_input_ten(ev[1]),
		.ref_input_eleven(ev[2]), .ref_input_twelve(ev[3]),
		.ref_input_thirteen(ev[4]), .main_ref_lost(ev[5]),
		.ext_frame_pulse_alarm(ev[6]), .aux_path_state_change(ev[7]),
		.phase_monitor_alarm(ev[8]), .aux_path_sources_lost(ev[9]),
		.bipolar_in2_code_error(ev[10]), .bipolar_in2_signal_loss(ev[11]),
		.irq(irq)
	);

	// 40 MHz
	always #12.5 pclk = ~pclk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	// Verdict, reached from the main flow and from any timeout
	task automatic tally_and_finish();
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg,
				seen, exp);
		end
	endtask

	// One APB transfer; an idle edge first keeps drives one per step
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		bit done;
		done = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int n = 0; n < 50 && !done; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				done = 1;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (!done)
		begin
			n_fail++;
			tally_and_finish();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
		input string msg);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0000_0000, rd, er);
		chk(rd, exp, msg);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset values, read back, upper bits dropped
	task automatic test_regs();
		rd_chk(ism_pkg::ADDR_MASK_MID, 32'h0000_0000, "mid rst");
		rd_chk(ism_pkg::ADDR_MASK_HIGH, 32'h0000_0000, "hi rst");
		chk(32'(irq), 32'h0000_0000, "irq rst");
		wr(ism_pkg::ADDR_MASK_MID, 32'hFFFF_FF5A);
		wr(ism_pkg::ADDR_MASK_HIGH, 32'h1234_56A5);
		rd_chk(ism_pkg::ADDR_MASK_MID, 32'h0000_005A, "mid rw");
		rd_chk(ism_pkg::ADDR_MASK_HIGH, 32'h0000_00A5, "hi rw");
		wr(ism_pkg::ADDR_MASK_MID, 32'h0000_0000);
		wr(ism_pkg::ADDR_MASK_HIGH, 32'h0000_0000);
		$display("test regs done");
	endtask

	// Unmapped access is refused and leaves the mid mask alone
	task automatic test_unmapped();
		logic [31:0] rd;
		logic er;
		apb(1'b1, 12'h200, 32'h0000_00FF, rd, er);
		chk(32'(er), 32'h0000_0001, "slverr wr");
		apb(1'b0, 12'h200, 32'h0000_0000, rd, er);
		chk(32'(er), 32'h0000_0001, "slverr rd");
		chk(rd, 32'h0000_0000, "unmapped data");
		rd_chk(ism_pkg::ADDR_MASK_MID, 32'h0000_0000, "mid kept");
		$display("test unmapped done");
	endtask

	// Each source blocked by a cleared bit, passed by its own bit
	task automatic test_gating();
		logic [11:0] ma;
		logic [11:0] pa;
		logic [31:0] b;
		for (int i = 0; i < 12; i++)
		begin
			ma = (i < 6) ? ism_pkg::ADDR_MASK_MID : ism_pkg::ADDR_MASK_HIGH;
			pa = (i < 6) ? ism_pkg::ADDR_PEND_MID : ism_pkg::ADDR_PEND_HIGH;
			b = 32'h0000_0001 << bit_of[i];
			@(posedge pclk);
			ev[i] <= 1'b1;
			@(posedge pclk);
			ev[i] <= 1'b0;
			#1;
			chk(32'(irq), 32'h0000_0000, "masked");
			rd_chk(pa, b, "pending");
			// All other bits on: a wrong bit position shows here
			wr(ma, ~b & 32'h0000_00FF);
			#1;
			chk(32'(irq), 32'h0000_0000, "other bits");
			wr(ma, b);
			#1;
			chk(32'(irq), 32'h0000_0001, "own bit");
			wr(pa, b);
			#1;
			chk(32'(irq), 32'h0000_0000, "cleared");
			wr(ma, 32'h0000_0000);
		end
		$display("test gating done");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		ev = 12'h000;
		n_fail = 0;
		n_tests = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		test_regs();
		test_unmapped();
		test_gating();
		tally_and_finish();
	end

endmodule

`default_nettype wire
